// ---- logic/solk_pkg.sv ----
// shared constants and types for the string and table lookup datapath
package solk_pkg;

   // ----------------------------------------------------------------
   // sizes
   // ----------------------------------------------------------------
   localparam int SOLK_WORD_W = 16;
   localparam int SOLK_ACC_DEPTH = 32;
   localparam int SOLK_IDX_W = 5;
   localparam int SOLK_LEN_W = 9;
   localparam logic [SOLK_LEN_W-1:0] SOLK_STR_BIAS = 9'h002;
   localparam logic [SOLK_LEN_W-1:0] SOLK_ACC_STR_MAX = 9'h020;
   localparam logic [SOLK_IDX_W-1:0] SOLK_OFFSET_SPAN = 5'h10;
   localparam logic [7:0] SOLK_CHAIN_RESET = 8'h00;
   localparam logic [15:0] SOLK_TP_RESET = 16'h0000;

   // ----------------------------------------------------------------
   // operations presented by the instruction stream
   // ----------------------------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP,
      OP_LOAD_CHAIN,
      OP_MOV_PM_DM,
      OP_MOV_PM_ACC,
      OP_MOVS_PM_DM,
      OP_MOVS_PM_ACC,
      OP_ADDS_PM,
      OP_STRING_BITWISE_CONJ_PM,
      OP_STRING_COMPARE_PM,
      OP_STRING_MINUS_PM,
      OP_STRING_EXCLUSIVE_OR_PM,
      OP_SAVE_TP,
      OP_PH_PREFIX,
      OP_ADDS_PH,
      OP_STRING_MINUS_PH,
      OP_COEF
   } solk_op_t;

   typedef struct packed {
      solk_op_t op;
      logic [SOLK_IDX_W-1:0] acc_ref;
      logic dst_paired;
      logic src_paired;
      logic [15:0] prog_mem_addr16;
      logic [15:0] dm_addr;
      logic [7:0] imm;
      logic rpt_valid;
      logic [7:0] rpt_count;
      logic prefix_carry;
   } solk_instr_t;

   typedef struct packed {
      logic zero;
      logic neg;
      logic carry;
   } solk_flags_t;

endpackage : solk_pkg

// ---- logic/solk_core.sv ----
// string operation and program-memory table lookup datapath
//
// Behaviour
// - string length is chain length register plus two words
// - accumulator string starts at the referenced accumulator and runs upward
// - chain length zero gives two words; one word means ordinary execution
// - arithmetic strings act as one number, carry chained word to word
// - flags describe the whole result; compare covers every bit
// - lowest address word goes to the lowest accumulator of the string
// - prefix carry enters the following product-high add or subtract
// - interrupts may be taken between steps of the product-high sequence
// - whole sequence uses the accumulator chosen by its first instruction
// - each product-high step advances a hidden index, not the pointer
// - sequence runs on through consecutive product-high steps; other instructions discard it
// - lookup address comes from the named accumulator or its partner
// - single lookup writes one program word to data memory or accumulator
// - string lookup copies a program string of chain length plus two words
// - string logic and arithmetic with a program address update the accumulators
// - table pointer is last read address plus one
// - table pointer can be saved to data memory
// - filter coefficient fetch continues from the table pointer
// - interrupts wait until an ordinary string operation completes
// - repeat count replaces chain length when a repeat precedes
// - accumulator strings are limited to thirty-two words
`timescale 1ns/1ps
module solk_core
   import solk_pkg::*;
#(
   parameter int ACC_DEPTH = SOLK_ACC_DEPTH
) (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic instr_valid_i,
   input wire solk_instr_t instr_i,
   output logic instr_ready_o,
   output logic busy_o,
   input wire logic irq_pending_i,
   output logic irq_take_o,
   input wire logic [SOLK_WORD_W-1:0] product_high_reg_i,
   output logic pm_rd_o,
   output logic [15:0] pm_addr_o,
   input wire logic [SOLK_WORD_W-1:0] pm_data_i,
   output logic dm_we_o,
   output logic [15:0] dm_addr_o,
   output logic [SOLK_WORD_W-1:0] dm_wdata_o,
   input wire logic coef_fetch_i,
   output logic coef_valid_o,
   output logic [SOLK_WORD_W-1:0] coef_data_o,
   output logic [15:0] table_pointer_o,
   output logic [7:0] chain_length_o,
   output solk_flags_t flags_o,
   input wire logic [SOLK_IDX_W-1:0] acc_rd_idx_i,
   output logic [SOLK_WORD_W-1:0] acc_rd_data_o
);

   // ----------------------------------------------------------------
   // parameter check
   // ----------------------------------------------------------------
   if (ACC_DEPTH != (1 << SOLK_IDX_W)) begin : g_depth_check
      $error("solk_core: ACC_DEPTH must equal the index range");
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [SOLK_IDX_W-1:0] acc_idx(input logic [SOLK_IDX_W-1:0] base, input logic paired);
      acc_idx = paired ? base + SOLK_OFFSET_SPAN : base;
   endfunction : acc_idx

   function automatic logic [SOLK_WORD_W:0] add_word(input logic [SOLK_WORD_W-1:0] a,
                                                     input logic [SOLK_WORD_W-1:0] b, input logic cin);
      add_word = {1'b0, a} + {1'b0, b} + {{SOLK_WORD_W{1'b0}}, cin};
   endfunction : add_word

   function automatic logic is_acc_string(input solk_op_t op);
      is_acc_string = op inside {OP_MOVS_PM_ACC, OP_ADDS_PM, OP_STRING_BITWISE_CONJ_PM, OP_STRING_COMPARE_PM, OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM};
   endfunction : is_acc_string

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {S_IDLE, S_FETCH, S_EXEC} solk_state_t;

   solk_state_t state;
   solk_instr_t cur;
   logic [SOLK_WORD_W-1:0] acc_file [ACC_DEPTH];
   logic [7:0] chain_length_reg;
   logic [15:0] table_pointer;
   logic [15:0] pm_ptr;
   logic [15:0] dm_ptr;
   logic [SOLK_LEN_W-1:0] word_len;
   logic [SOLK_LEN_W-1:0] word_cnt;
   logic carry;
   logic all_zero;
   logic seq_active;
   logic [SOLK_IDX_W-1:0] seq_idx;
   logic seq_carry;
   logic [SOLK_IDX_W-1:0] dst_base;
   logic [SOLK_IDX_W-1:0] src_base;

   logic start;
   logic is_string;
   logic last_word;
   logic [SOLK_LEN_W-1:0] next_len;
   logic [SOLK_IDX_W-1:0] wr_idx;
   logic [SOLK_WORD_W-1:0] src_word;
   logic [SOLK_WORD_W:0] sum;
   logic [SOLK_WORD_W-1:0] result;
   logic ph_sub;
   logic [SOLK_IDX_W-1:0] ph_idx;
   logic [SOLK_WORD_W:0] ph_sum;

   assign start = ce_i && instr_valid_i && state == S_IDLE;
   assign is_string = cur.op inside {OP_MOVS_PM_DM, OP_MOVS_PM_ACC, OP_ADDS_PM, OP_STRING_BITWISE_CONJ_PM,
                                     OP_STRING_COMPARE_PM, OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM};
   assign last_word = word_cnt == word_len - 9'h001;
   assign wr_idx = dst_base + word_cnt[SOLK_IDX_W-1:0];
   assign src_word = acc_file[src_base + word_cnt[SOLK_IDX_W-1:0]];

   // ----------------------------------------------------------------
   // length of the operation
   // ----------------------------------------------------------------
   always_comb begin
      // zero gives two words, non-string stays one word
      next_len = 9'h001;
      if (instr_i.op inside {OP_MOVS_PM_DM, OP_MOVS_PM_ACC, OP_ADDS_PM, OP_STRING_BITWISE_CONJ_PM, OP_STRING_COMPARE_PM,
                             OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM}) begin
         next_len = (instr_i.rpt_valid ? {1'b0, instr_i.rpt_count} : {1'b0, chain_length_reg}) + SOLK_STR_BIAS;
         if (is_acc_string(instr_i.op) && next_len > SOLK_ACC_STR_MAX) begin
            next_len = SOLK_ACC_STR_MAX;
         end
      end
   end

   // ----------------------------------------------------------------
   // word datapath
   // ----------------------------------------------------------------
   always_comb begin
      // carry chained into the next word
      sum = add_word(src_word, (cur.op == OP_STRING_MINUS_PM || cur.op == OP_STRING_COMPARE_PM) ? ~pm_data_i : pm_data_i, carry);
      unique case (cur.op)
         OP_STRING_BITWISE_CONJ_PM: result = src_word & pm_data_i;
         OP_STRING_EXCLUSIVE_OR_PM: result = src_word ^ pm_data_i;
         OP_ADDS_PM, OP_STRING_MINUS_PM, OP_STRING_COMPARE_PM: result = sum[SOLK_WORD_W-1:0];
         default: result = pm_data_i;
      endcase
   end

   // sequence keeps the first instruction's accumulator
   assign ph_sub = instr_i.op == OP_STRING_MINUS_PH;
   assign ph_idx = seq_active ? seq_idx : acc_idx(instr_i.acc_ref, instr_i.dst_paired);
   // prefix carry feeds the product-high step
   assign ph_sum = add_word(acc_file[ph_idx], ph_sub ? ~product_high_reg_i : product_high_reg_i,
                            seq_active ? seq_carry : ph_sub);

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         state <= S_IDLE;
         cur <= '0;
         word_len <= 9'h001;
         word_cnt <= 9'h000;
         pm_ptr <= 16'h0000;
         dm_ptr <= 16'h0000;
         dst_base <= 5'h00;
         src_base <= 5'h00;
      end else if (ce_i) begin
         unique case (state)
            S_IDLE: begin
               if (instr_valid_i) begin
                  cur <= instr_i;
                  word_len <= next_len;
                  word_cnt <= 9'h000;
                  dm_ptr <= instr_i.dm_addr;
                  // string starts at the referenced accumulator
                  dst_base <= acc_idx(instr_i.acc_ref, instr_i.dst_paired);
                  src_base <= acc_idx(instr_i.acc_ref, instr_i.src_paired);
                  // lookup address held in the named accumulator
                  pm_ptr <= instr_i.op inside {OP_ADDS_PM, OP_STRING_BITWISE_CONJ_PM, OP_STRING_COMPARE_PM, OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM} ?
                            instr_i.prog_mem_addr16 : acc_file[acc_idx(instr_i.acc_ref, instr_i.src_paired)];
                  if (instr_i.op inside {OP_MOV_PM_DM, OP_MOV_PM_ACC, OP_MOVS_PM_DM, OP_MOVS_PM_ACC, OP_ADDS_PM,
                                         OP_STRING_BITWISE_CONJ_PM, OP_STRING_COMPARE_PM, OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM}) begin
                     state <= S_FETCH;
                  end
               end else if (coef_fetch_i) begin
                  // coefficients continue from the table pointer
                  cur.op <= OP_COEF;
                  word_len <= 9'h001;
                  word_cnt <= 9'h000;
                  pm_ptr <= table_pointer;
                  state <= S_FETCH;
               end
            end
            S_FETCH: state <= S_EXEC;
            S_EXEC: begin
               word_cnt <= word_cnt + 9'h001;
               pm_ptr <= pm_ptr + 16'h0001;
               dm_ptr <= dm_ptr + 16'h0001;
               state <= last_word ? S_IDLE : S_FETCH;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // chain length register
   // ----------------------------------------------------------------
   // only an explicit load changes it
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         chain_length_reg <= SOLK_CHAIN_RESET;
      end else if (start && instr_i.op == OP_LOAD_CHAIN) begin
         chain_length_reg <= instr_i.imm;
      end
   end

   // ----------------------------------------------------------------
   // table pointer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         table_pointer <= SOLK_TP_RESET;
      end else if (ce_i && state == S_FETCH) begin
         table_pointer <= pm_ptr + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // product-high sequence state
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         seq_active <= 1'b0;
         seq_idx <= 5'h00;
         seq_carry <= 1'b0;
      end else if (start) begin
         unique case (instr_i.op)
            OP_PH_PREFIX: begin
               seq_active <= 1'b1;
               seq_idx <= acc_idx(instr_i.acc_ref, instr_i.dst_paired) + 5'h01;
               seq_carry <= instr_i.prefix_carry;
            end
            OP_ADDS_PH, OP_STRING_MINUS_PH: begin
               seq_idx <= ph_idx + 5'h01;
               seq_carry <= ph_sum[SOLK_WORD_W];
               seq_active <= 1'b1;
            end
            // any other instruction discards the sequence
            default: seq_active <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // accumulator file
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i) begin
      if (ce_i && state == S_EXEC && cur.op inside {OP_MOV_PM_ACC, OP_MOVS_PM_ACC, OP_ADDS_PM, OP_STRING_BITWISE_CONJ_PM,
                                                   OP_STRING_COMPARE_PM, OP_STRING_MINUS_PM, OP_STRING_EXCLUSIVE_OR_PM}) begin
         // word k lands in accumulator base plus k
         acc_file[wr_idx] <= result;
      end else if (start && instr_i.op inside {OP_ADDS_PH, OP_STRING_MINUS_PH}) begin
         acc_file[ph_idx] <= ph_sum[SOLK_WORD_W-1:0];
      end
   end

   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         acc_rd_data_o <= 16'h0000;
      end else if (ce_i) begin
         acc_rd_data_o <= acc_file[acc_rd_idx_i];
      end
   end

   // ----------------------------------------------------------------
   // carry, zero and flags
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         carry <= 1'b0;
         all_zero <= 1'b1;
         flags_o <= '0;
      end else if (start) begin
         carry <= instr_i.op inside {OP_STRING_MINUS_PM, OP_STRING_COMPARE_PM};
         all_zero <= 1'b1;
         if (instr_i.op inside {OP_ADDS_PH, OP_STRING_MINUS_PH}) begin
            flags_o <= '{zero: ph_sum[SOLK_WORD_W-1:0] == 16'h0000, neg: ph_sum[SOLK_WORD_W-1],
                         carry: ph_sum[SOLK_WORD_W]};
         end
      end else if (ce_i && state == S_EXEC) begin
         // carry and zero held across words
         if (cur.op inside {OP_ADDS_PM, OP_STRING_MINUS_PM, OP_STRING_COMPARE_PM}) begin
            carry <= sum[SOLK_WORD_W];
         end
         all_zero <= all_zero && result == 16'h0000;
         if (last_word && cur.op != OP_COEF) begin
            flags_o <= '{zero: all_zero && result == 16'h0000, neg: result[SOLK_WORD_W-1],
                         carry: cur.op inside {OP_ADDS_PM, OP_STRING_MINUS_PM, OP_STRING_COMPARE_PM} ? sum[SOLK_WORD_W] : carry};
         end
      end
   end

   // ----------------------------------------------------------------
   // data memory and coefficient outputs
   // ----------------------------------------------------------------
   always_ff @(posedge mclk_i or posedge reset_i) begin
      if (reset_i) begin
         dm_we_o <= 1'b0;
         dm_addr_o <= 16'h0000;
         dm_wdata_o <= 16'h0000;
         coef_valid_o <= 1'b0;
         coef_data_o <= 16'h0000;
      end else if (ce_i) begin
         dm_we_o <= 1'b0;
         coef_valid_o <= 1'b0;
         if (start && instr_i.op == OP_SAVE_TP) begin
            // table pointer saved to data memory
            dm_we_o <= 1'b1;
            dm_addr_o <= instr_i.dm_addr;
            dm_wdata_o <= table_pointer;
         end else if (state == S_EXEC && cur.op inside {OP_MOV_PM_DM, OP_MOVS_PM_DM}) begin
            dm_we_o <= 1'b1;
            dm_addr_o <= dm_ptr;
            dm_wdata_o <= pm_data_i;
         end else if (state == S_EXEC && cur.op == OP_COEF) begin
            coef_valid_o <= 1'b1;
            coef_data_o <= pm_data_i;
         end
      end
   end

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   assign instr_ready_o = state == S_IDLE;
   assign busy_o = state != S_IDLE;
   // interrupts wait for the string to finish
   // sequence steps leave the block idle, so interrupts pass
   assign irq_take_o = irq_pending_i && state == S_IDLE;
   assign pm_rd_o = ce_i && state == S_FETCH;
   assign pm_addr_o = pm_ptr;
   assign table_pointer_o = table_pointer;
   assign chain_length_o = chain_length_reg;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence word_step;
      pm_rd_o ##1 state == S_EXEC;
   endsequence

   a_len_bias: assert property (@(posedge mclk_i) disable iff (reset_i)
      start && instr_i.op == OP_MOVS_PM_DM && !instr_i.rpt_valid
      |=> word_len == {1'b0, $past(chain_length_reg)} + 9'h002)
      else $error("string length not chain length plus two");

   a_rpt_len: assert property (@(posedge mclk_i) disable iff (reset_i)
      start && instr_i.op inside {OP_MOVS_PM_DM, OP_MOVS_PM_ACC} && instr_i.rpt_valid && instr_i.rpt_count <= 8'h1E
      |=> word_len == {1'b0, $past(instr_i.rpt_count)} + 9'h002)
      else $error("repeat count not used as length");

   a_acc_limit: assert property (@(posedge mclk_i) disable iff (reset_i)
      state != S_IDLE && is_acc_string(cur.op) |-> word_len <= 9'h020)
      else $error("accumulator string longer than 32");

   a_tp_follow: assert property (@(posedge mclk_i) disable iff (reset_i)
      pm_rd_o |=> table_pointer == $past(pm_addr_o) + 16'h0001)
      else $error("table pointer not read address plus one");

   a_irq_hold: assert property (@(posedge mclk_i) disable iff (reset_i)
      busy_o |-> !irq_take_o)
      else $error("interrupt taken during string");

   a_seq_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
      start && !(instr_i.op inside {OP_PH_PREFIX, OP_ADDS_PH, OP_STRING_MINUS_PH}) |=> !seq_active)
      else $error("sequence state survived another instruction");

   a_seq_index: assert property (@(posedge mclk_i) disable iff (reset_i)
      start && seq_active && instr_i.op inside {OP_ADDS_PH, OP_STRING_MINUS_PH} |=> seq_idx == $past(seq_idx) + 5'h01)
      else $error("hidden index did not advance");

   a_word_walk: assert property (@(posedge mclk_i) disable iff (reset_i)
      ce_i && state == S_FETCH && word_cnt == 9'h000 ##1 ce_i |-> ##0 state == S_EXEC)
      else $error("fetch not followed by execute");

   a_dm_order: assert property (@(posedge mclk_i) disable iff (reset_i)
      word_step ##1 (ce_i && dm_we_o && cur.op == OP_MOVS_PM_DM && state == S_FETCH) ##1 ce_i ##1 dm_we_o
      |-> dm_addr_o == $past(dm_addr_o, 2) + 16'h0001)
      else $error("string words not written to rising addresses");

   a_chain_keep: assert property (@(posedge mclk_i) disable iff (reset_i)
      !(start && instr_i.op == OP_LOAD_CHAIN) |=> $stable(chain_length_reg))
      else $error("chain length changed without a load");

endmodule : solk_core

// ---- verification/tb.sv ----
// self-checking bench for the string and table lookup datapath
`timescale 1ns/1ps
module tb;
   import solk_pkg::*;
   logic mclk_i = 1'b0;
   logic reset_i = 1'b1;
   logic ce_i = 1'b1;
   logic instr_valid_i = 1'b0;
   logic irq_pending_i = 1'b0;
   logic coef_fetch_i = 1'b0;
   solk_instr_t instr_i = '0;
   logic [15:0] product_high_reg_i = 16'h0000;
   logic [15:0] pm_data_i = 16'h0000;
   logic [4:0] acc_rd_idx_i = 5'h00;
   logic instr_ready_o, busy_o, irq_take_o, pm_rd_o, dm_we_o, coef_valid_o;
   logic [15:0] pm_addr_o, dm_addr_o, dm_wdata_o, coef_data_o, table_pointer_o, acc_rd_data_o;
   logic [7:0] chain_length_o;
   solk_flags_t flags_o;
   logic [31:0] dm_q[$];
   int num_errors = 0;
   int n_tests = 0;

   solk_core u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .instr_valid_i(instr_valid_i),
      .instr_i(instr_i), .instr_ready_o(instr_ready_o), .busy_o(busy_o), .irq_pending_i(irq_pending_i),
      .irq_take_o(irq_take_o), .product_high_reg_i(product_high_reg_i), .pm_rd_o(pm_rd_o),
      .pm_addr_o(pm_addr_o), .pm_data_i(pm_data_i), .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o),
      .dm_wdata_o(dm_wdata_o), .coef_fetch_i(coef_fetch_i), .coef_valid_o(coef_valid_o),
      .coef_data_o(coef_data_o), .table_pointer_o(table_pointer_o), .chain_length_o(chain_length_o),
      .flags_o(flags_o), .acc_rd_idx_i(acc_rd_idx_i), .acc_rd_data_o(acc_rd_data_o));

   initial begin
      forever #10 mclk_i = ~mclk_i;
   end

   // ------------------------------------------------------------
   // program memory and data memory capture
   // ------------------------------------------------------------
   function automatic logic [15:0] pm(input logic [15:0] a);
      if (a[15:12] == 4'h0) return 16'h0000;
      if (a[15:12] == 4'h1) return 16'hFFFF;
      return {a[7:0], ~a[7:0]};
   endfunction : pm

   // data toggles when not read so a late sample is caught
   always @(posedge mclk_i) begin
      pm_data_i <= pm_rd_o ? pm(pm_addr_o) : ~pm_data_i;
      if (dm_we_o === 1'b1) dm_q.push_back({dm_addr_o, dm_wdata_o});
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic summarize();
      $display("checks %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : summarize

   function automatic solk_instr_t mk(input solk_op_t op, input logic [4:0] r, input logic [15:0] pma,
                                      input logic [15:0] dm);
      mk = '0;
      mk.op = op;
      mk.acc_ref = r;
      mk.prog_mem_addr16 = pma;
      mk.dm_addr = dm;
   endfunction : mk

   task automatic exec(input solk_instr_t ins);
      int i;
      @(posedge mclk_i);
      instr_i <= ins;
      instr_valid_i <= 1'b1;
      @(posedge mclk_i);
      instr_valid_i <= 1'b0;
      #1;
      for (i = 0; i < 200 && instr_ready_o !== 1'b1; i++) begin
         if (busy_o === 1'b1) chk("irq take while busy", 16'h0000, {15'h0000, irq_take_o});
         @(posedge mclk_i);
         #1;
      end
      if (i == 200) begin
         num_errors++;
         $display("unexpected ready: expected 1, seen hang");
         summarize();
      end
   endtask : exec

   task automatic chain(input logic [7:0] n);
      solk_instr_t ins;
      ins = mk(OP_LOAD_CHAIN, 5'h00, 16'h0000, 16'h0000);
      ins.imm = n;
      exec(ins);
   endtask : chain

   task automatic chk_acc(input logic [4:0] idx, input logic [15:0] exp);
      @(posedge mclk_i);
      acc_rd_idx_i <= idx;
      @(posedge mclk_i);
      #1;
      chk($sformatf("acc %0d", idx), exp, acc_rd_data_o);
   endtask : chk_acc

   task automatic chk_dm(input logic [15:0] a, input logic [15:0] d);
      logic [31:0] w;
      repeat (2) @(posedge mclk_i);
      w = (dm_q.size() > 0) ? dm_q.pop_front() : 32'h0000_0000;
      chk("dm addr", a, w[31:16]);
      chk("dm data", d, w[15:0]);
   endtask : chk_dm

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // length, carry and flags
   task automatic sc_arith();
      chain(8'h1E);
      exec(mk(OP_STRING_BITWISE_CONJ_PM, 5'h00, 16'h0000, 16'h0000));
      chk_acc(5'h1F, 16'h0000);
      chain(8'h00);
      exec(mk(OP_ADDS_PM, 5'h04, 16'h1000, 16'h0000));
      exec(mk(OP_ADDS_PM, 5'h04, 16'h1000, 16'h0000));
      chk("flags", 16'h0003, {13'h0000, flags_o});
      chk_acc(5'h04, 16'hFFFE);
      chk_acc(5'h05, 16'hFFFF);
      chk_acc(5'h06, 16'h0000);
      exec(mk(OP_STRING_EXCLUSIVE_OR_PM, 5'h04, 16'h1000, 16'h0000));
      chk("zero neg", 16'h0000, {14'h0000, flags_o.zero, flags_o.neg});
      exec(mk(OP_STRING_COMPARE_PM, 5'h04, 16'h1000, 16'h0000));
      chk("flags", 16'h0000, {13'h0000, flags_o});
      chk_acc(5'h04, 16'h0002);
      exec(mk(OP_STRING_COMPARE_PM, 5'h00, 16'h0000, 16'h0000));
      chk("flags", 16'h0005, {13'h0000, flags_o});
   endtask : sc_arith

   task automatic sc_lookup();
      solk_instr_t ins;
      product_high_reg_i <= 16'h2040;
      exec(mk(OP_ADDS_PH, 5'h0A, 16'h0000, 16'h0000));
      ins = mk(OP_MOVS_PM_ACC, 5'h0A, 16'h0000, 16'h0000);
      ins.dst_paired = 1'b1;
      ins.rpt_valid = 1'b1;
      ins.rpt_count = 8'h01;
      exec(ins);
      chk("table pointer", 16'h2043, table_pointer_o);
      chk("chain length", 16'h0000, {8'h00, chain_length_o});
      chk_acc(5'h1A, 16'h40BF);
      chk_acc(5'h1C, 16'h42BD);
      exec(mk(OP_MOVS_PM_DM, 5'h0A, 16'h0000, 16'h0300));
      chk_dm(16'h0300, 16'h40BF);
      chk_dm(16'h0301, 16'h41BE);
      exec(mk(OP_MOV_PM_DM, 5'h0A, 16'h0000, 16'h0320));
      chk_dm(16'h0320, 16'h40BF);
      exec(mk(OP_SAVE_TP, 5'h00, 16'h0000, 16'h0310));
      chk_dm(16'h0310, 16'h2041);
   endtask : sc_lookup

   // coefficient fetch continues from the pointer
   task automatic sc_coef();
      int i;
      @(posedge mclk_i);
      coef_fetch_i <= 1'b1;
      @(posedge mclk_i);
      coef_fetch_i <= 1'b0;
      #1;
      for (i = 0; i < 10 && coef_valid_o !== 1'b1; i++) begin
         @(posedge mclk_i);
         #1;
      end
      if (i == 10) begin
         num_errors++;
         $display("unexpected coef valid: expected 1, seen timeout");
         summarize();
      end
      chk("coef data", 16'h41BE, coef_data_o);
      chk("table pointer", 16'h2042, table_pointer_o);
   endtask : sc_coef

   task automatic sc_ph();
      solk_instr_t ins;
      product_high_reg_i <= 16'h0005;
      ins = mk(OP_PH_PREFIX, 5'h00, 16'h0000, 16'h0000);
      ins.prefix_carry = 1'b1;
      exec(ins);
      chk("irq take", 16'h0001, {15'h0000, irq_take_o});
      exec(mk(OP_ADDS_PH, 5'h14, 16'h0000, 16'h0000));
      exec(mk(OP_ADDS_PH, 5'h14, 16'h0000, 16'h0000));
      exec(mk(OP_NOP, 5'h00, 16'h0000, 16'h0000));
      exec(mk(OP_ADDS_PH, 5'h0C, 16'h0000, 16'h0000));
      ins.acc_ref = 5'h06;
      ins.prefix_carry = 1'b0;
      exec(ins);
      exec(mk(OP_STRING_MINUS_PH, 5'h14, 16'h0000, 16'h0000));
      chk_acc(5'h01, 16'h0006);
      chk_acc(5'h02, 16'h0005);
      chk_acc(5'h14, 16'h0000);
      chk_acc(5'h0C, 16'h0005);
      chk_acc(5'h07, 16'hFFFA);
   endtask : sc_ph

   initial begin
      @(posedge mclk_i);
      #1;
      chk("ready in reset", 16'h0001, {15'h0000, instr_ready_o});
      chk("busy in reset", 16'h0000, {15'h0000, busy_o});
      chk("chain reset", 16'h0000, {8'h00, chain_length_o});
      chk("pointer reset", 16'h0000, table_pointer_o);
      repeat (4) @(posedge mclk_i);
      reset_i <= 1'b0;
      irq_pending_i <= 1'b1;
      sc_arith();
      sc_lookup();
      sc_coef();
      sc_ph();
      summarize();
   end
endmodule : tb
